/* hdl/spi_port_pkg.sv */
// Purpose: shared constants and types for the paged burst spi slave port
// Assumes: one system clock that oversamples the serial clock by at least 8x
// Notes: the page register is four bytes wide; only its low half forms addresses
`default_nettype none

package spi_port_pkg;

   // widths of the serial port
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 16;
   localparam int OFF_W = 15;
   localparam int PAGE_W = 32;

   // direction flag sits in the top bit of the first command byte
   localparam int RW_BIT = 7;

   // page register windows: four bytes in each offset mode
   localparam logic [6:0] PAGE_WIN_SHORT = 7'h7C;
   localparam logic [14:0] PAGE_WIN_LONG = 15'h7FFC;

   // page register after reset: bit 15 set, as register accesses need it
   localparam logic [31:0] PAGE_RESET = 32'h0000_8000;

   // bit counter value of the last bit in a byte
   localparam logic [2:0] LAST_BIT = 3'h7;

   // one-hot port states
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_CMD = 5'h02,
      ST_ADDR = 5'h04,
      ST_WDATA = 5'h08,
      ST_RDATA = 5'h10
   } port_state_t;

   // one write toward the register space
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [BYTE_W-1:0] data;
   } wr_req_t;

   // whole state of the port core
   typedef struct packed {
      logic sclk_s1;
      logic sclk_s2;
      logic sclk_s3;
      logic cs_n_s1;
      logic cs_n_s2;
      logic sdi_s1;
      logic sdi_s2;
      logic sdio_s1;
      logic sdio_s2;
      port_state_t st;
      logic [2:0] bit_cnt;
      logic [BYTE_W-1:0] rx_sr;
      logic rw;
      logic [OFF_W-1:0] offset;
      logic [PAGE_W-1:0] page;
      logic [BYTE_W-1:0] tx_sr;
      logic [2:0] tx_cnt;
      logic load_pend;
      logic have_data;
      logic [BYTE_W-1:0] rd_byte;
      logic fetch_pend;
      logic rd_req;
      logic [ADDR_W-1:0] rd_addr;
      logic sdio_out;
      logic sdio_oe;
      logic push;
      wr_req_t push_data;
      logic overflow;
   } core_state_t;

endpackage

`default_nettype wire

/* hdl/spi_burst_buffer.sv */
// Purpose: two-entry skid buffer between the serial side and the register side
// Assumes: both sides on the same clock
// Notes: outputs come straight from flops; in_ready drops only when both entries hold words
`default_nettype none

module spi_burst_buffer #(
   parameter int WIDTH = 24
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // filling side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // draining side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);

   // head feeds the output, spare catches a word while the head is stalled
   typedef struct packed {
      logic head_v;
      logic [WIDTH-1:0] head;
      logic spare_v;
      logic [WIDTH-1:0] spare;
   } buf_state_t;

   buf_state_t q; // registered state
   buf_state_t next_q; // next state

   // pop, refill head from spare, then accept the new word
   always_comb begin
      next_q = q;
      if (out_ready && q.head_v) begin
         next_q.head_v = 1'b0;
      end
      if (!next_q.head_v && q.spare_v) begin
         // spare moves up first so word order is kept
         next_q.head = q.spare;
         next_q.head_v = 1'b1;
         next_q.spare_v = 1'b0;
      end
      if (in_valid && !q.spare_v) begin
         if (!next_q.head_v) begin
            next_q.head = in_data;
            next_q.head_v = 1'b1;
         end else begin
            next_q.spare = in_data;
            next_q.spare_v = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // ready is taken from the flop, so it is honest one cycle ahead
   assign in_ready = !q.spare_v;
   assign out_valid = q.head_v;
   assign out_data = q.head;

endmodule

`default_nettype wire

/* hdl/spi_paged_port.sv */
// Purpose: spi slave port giving byte bursts into a paged 16-bit register space
// Assumes: clk at 10 MHz, serial clock at most clk/8; rd_ack within 2 clk of rd_req
// Notes: all pins pass two flops; page register lives here and is not forwarded
//
// How it works
// - pointer steps by one per data byte
// - command top bit: zero write, one read
// - short mode: page at offset 7C, four bytes
// - long mode: page at offset 7FFC, four bytes
// - half delay moves read bits half period
// - chip select high releases the data pin
// - short address: nine page bits, seven offset
// - long address: one page bit, fifteen offset
// - four-wire input pin, three-wire shared pin
`default_nettype none

module spi_paged_port (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_data_input_pin,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   // configuration
   input wire logic offset_width_setting,
   input wire logic spi_wire_mode_setting,
   input wire logic clock_edge_select,
   input wire logic read_half_delay,
   // write stream to the register space
   output logic wr_valid,
   output spi_port_pkg::wr_req_t wr_data,
   input wire logic wr_ready,
   // read fetch from the register space
   output logic rd_req,
   output logic [spi_port_pkg::ADDR_W-1:0] rd_addr,
   input wire logic rd_ack,
   input wire logic [spi_port_pkg::BYTE_W-1:0] rd_data,
   // status
   output logic overflow
);

   spi_port_pkg::core_state_t q; // registered state
   spi_port_pkg::core_state_t next_q; // next state
   logic buf_ready; // buffer can take a word
   logic rise; // serial clock rising edge seen
   logic fall; // serial clock falling edge seen
   logic samp; // edge that captures host bits
   logic launch; // edge that shifts out read bits
   logic din; // selected receive bit
   logic [spi_port_pkg::BYTE_W-1:0] rx_byte; // byte as it completes
   logic byte_done; // last bit of a receive byte
   logic load; // read byte enters the shifter

   // full register address from offset and page
   function automatic logic [15:0] full_addr(input logic [14:0] off, input logic [31:0] pg,
                                             input logic two_byte);
      full_addr = two_byte ? {pg[15], off} : {pg[15:7], off[6:0]};
   endfunction

   // true when the offset falls in the page register window
   function automatic logic in_window(input logic [14:0] off, input logic two_byte);
      in_window = two_byte ? (off[14:2] == spi_port_pkg::PAGE_WIN_LONG[14:2])
                           : (off[6:2] == spi_port_pkg::PAGE_WIN_SHORT[6:2]);
   endfunction

   // edges come from the second and third flop, never the first
   assign rise = q.sclk_s2 && !q.sclk_s3;
   assign fall = !q.sclk_s2 && q.sclk_s3;
   assign samp = clock_edge_select ? fall : rise;
   // with the delay option, bits leave on the opposite edge, half a period later
   assign launch = read_half_delay ? (clock_edge_select ? rise : fall) : samp;
   assign din = spi_wire_mode_setting ? q.sdio_s2 : q.sdi_s2;
   assign rx_byte = {q.rx_sr[6:0], din};
   assign byte_done = !q.cs_n_s2 && samp && (q.bit_cnt == spi_port_pkg::LAST_BIT)
                      && (q.st != spi_port_pkg::ST_RDATA) && (q.st != spi_port_pkg::ST_IDLE);
   assign load = !q.cs_n_s2 && (q.st == spi_port_pkg::ST_RDATA) && q.load_pend && q.have_data;

   // whole port behaviour
   always_comb begin
      logic fetch_go; // start a read fetch
      logic [14:0] fetch_off; // offset to fetch
      logic start_data; // address phase just ended
      logic [1:0] idx; // page byte index
      fetch_go = 1'b0;
      fetch_off = q.offset;
      start_data = 1'b0;
      idx = q.offset[1:0];
      next_q = q;
      // two-flop synchronisers on every pin
      next_q.sclk_s1 = sclk;
      next_q.sclk_s2 = q.sclk_s1;
      next_q.sclk_s3 = q.sclk_s2;
      next_q.cs_n_s1 = cs_n;
      next_q.cs_n_s2 = q.cs_n_s1;
      next_q.sdi_s1 = serial_data_input_pin;
      next_q.sdi_s2 = q.sdi_s1;
      next_q.sdio_s1 = sdio_in;
      next_q.sdio_s2 = q.sdio_s1;
      next_q.rd_req = 1'b0;
      next_q.push = 1'b0;
      // pin is driven only while a read burst runs
      next_q.sdio_oe = !q.cs_n_s2 && (q.st == spi_port_pkg::ST_RDATA);
      // a word the buffer could not take is lost; flag stays until reset
      if (q.push && !buf_ready) begin
         next_q.overflow = 1'b1;
      end
      // read answer from the register space
      if (rd_ack && q.fetch_pend) begin
         next_q.fetch_pend = 1'b0;
         next_q.have_data = 1'b1;
         next_q.rd_byte = rd_data;
      end
      if (q.cs_n_s2) begin
         // deselected: every transfer restarts from a fresh command byte
         next_q.st = spi_port_pkg::ST_IDLE;
         next_q.bit_cnt = 3'h0;
         next_q.tx_cnt = 3'h0;
         next_q.load_pend = 1'b0;
         next_q.have_data = 1'b0;
      end else begin
         case (q.st)
            spi_port_pkg::ST_IDLE: begin
               next_q.st = spi_port_pkg::ST_CMD;
            end
            spi_port_pkg::ST_CMD, spi_port_pkg::ST_ADDR, spi_port_pkg::ST_WDATA: begin
               if (samp) begin
                  next_q.rx_sr = rx_byte;
                  next_q.bit_cnt = 3'(q.bit_cnt + 3'h1);
               end
               if (byte_done) begin
                  if (q.st == spi_port_pkg::ST_CMD) begin
                     next_q.rw = rx_byte[spi_port_pkg::RW_BIT];
                     if (offset_width_setting) begin
                        next_q.offset = {rx_byte[6:0], 8'h00};
                        next_q.st = spi_port_pkg::ST_ADDR;
                     end else begin
                        next_q.offset = {8'h00, rx_byte[6:0]};
                        start_data = 1'b1;
                     end
                  end else if (q.st == spi_port_pkg::ST_ADDR) begin
                     next_q.offset = {q.offset[14:8], rx_byte};
                     start_data = 1'b1;
                  end else begin
                     if (in_window(q.offset, offset_width_setting)) begin
                        next_q.page[{idx, 3'h0} +: 8] = rx_byte;
                     end else begin
                        next_q.push = 1'b1;
                        next_q.push_data.addr = full_addr(q.offset, q.page,
                                                          offset_width_setting);
                        next_q.push_data.data = rx_byte;
                     end
                     next_q.offset = 15'(q.offset + 15'h0001);
                  end
               end
               if (start_data) begin
                  if (next_q.rw) begin
                     next_q.st = spi_port_pkg::ST_RDATA;
                     fetch_go = 1'b1;
                     fetch_off = next_q.offset;
                     // without delay the first launch edge is the one just seen
                     next_q.load_pend = !read_half_delay;
                  end else begin
                     next_q.st = spi_port_pkg::ST_WDATA;
                  end
               end
            end
            spi_port_pkg::ST_RDATA: begin
               if (launch) begin
                  if (q.tx_cnt == 3'h0) begin
                     next_q.load_pend = 1'b1;
                  end else begin
                     next_q.tx_sr = {q.tx_sr[6:0], 1'b0};
                     next_q.sdio_out = q.tx_sr[6];
                     next_q.tx_cnt = 3'(q.tx_cnt + 3'h1);
                  end
               end
               if (load) begin
                  // byte leaves msb first; pointer moves on and prefetches
                  next_q.tx_sr = q.rd_byte;
                  next_q.sdio_out = q.rd_byte[7];
                  next_q.tx_cnt = 3'h1;
                  next_q.load_pend = 1'b0;
                  next_q.have_data = 1'b0;
                  next_q.offset = 15'(q.offset + 15'h0001);
                  fetch_go = 1'b1;
                  fetch_off = 15'(q.offset + 15'h0001);
               end
            end
            default: begin
               next_q.st = spi_port_pkg::ST_IDLE;
            end
         endcase
      end
      // page bytes answer locally, everything else goes out as a fetch
      if (fetch_go) begin
         idx = fetch_off[1:0];
         if (in_window(fetch_off, offset_width_setting)) begin
            next_q.have_data = 1'b1;
            next_q.rd_byte = q.page[{idx, 3'h0} +: 8];
         end else begin
            next_q.have_data = 1'b0;
            next_q.fetch_pend = 1'b1;
            next_q.rd_req = 1'b1;
            next_q.rd_addr = full_addr(fetch_off, next_q.page, offset_width_setting);
         end
      end
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.cs_n_s1 <= 1'b1;
         q.cs_n_s2 <= 1'b1;
         q.st <= spi_port_pkg::ST_IDLE;
         q.page <= spi_port_pkg::PAGE_RESET;
      end else begin
         q <= next_q;
      end
   end

   // two entries absorb a short stall on the register side
   spi_burst_buffer #(
      .WIDTH($bits(spi_port_pkg::wr_req_t))
   ) u_buf (
      .clk(clk),
      .rst(rst),
      .in_valid(q.push),
      .in_data(q.push_data),
      .in_ready(buf_ready),
      .out_valid(wr_valid),
      .out_data(wr_data),
      .out_ready(wr_ready)
   );

   // outputs straight from state flops
   assign sdio_out = q.sdio_out;
   assign sdio_oe = q.sdio_oe;
   assign rd_req = q.rd_req;
   assign rd_addr = q.rd_addr;
   assign overflow = q.overflow;

   // checks on the port's own behaviour
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_cs_release_hiz: assert property (q.cs_n_s2 |=> !q.sdio_oe)
      else $error("data pin still driven after deselect");
   a_cs_restart_cmd: assert property (q.cs_n_s2 |=> q.st == spi_port_pkg::ST_IDLE
                                      && q.bit_cnt == 3'h0)
      else $error("decoder not cleared on deselect");
   a_read_drives_pin: assert property (!q.cs_n_s2 && q.st == spi_port_pkg::ST_RDATA
                                       |=> q.sdio_oe)
      else $error("read burst not driving the data pin");
   a_cmd_direction: assert property (byte_done && q.st == spi_port_pkg::ST_CMD
                                     |=> q.rw == $past(q.rx_sr[6]))
      else $error("direction flag not taken from command msb");
   a_ptr_write_step: assert property (byte_done && q.st == spi_port_pkg::ST_WDATA
                                      |=> q.offset == 15'($past(q.offset) + 15'h0001))
      else $error("write pointer did not advance by one");
   a_short_addr_form: assert property (q.push && !offset_width_setting
                                       |-> q.push_data.addr == {q.page[15:7],
                                       7'(q.offset[6:0] - 7'h01)})
      else $error("short mode address wrongly formed");
   a_long_addr_form: assert property (q.push && offset_width_setting
                                      |-> q.push_data.addr == {q.page[15],
                                      15'(q.offset - 15'h0001)})
      else $error("long mode address wrongly formed");
   a_short_page_hold: assert property (byte_done && q.st == spi_port_pkg::ST_WDATA
                                       && !offset_width_setting
                                       |=> q.push != in_window($past(q.offset), 1'b0))
      else $error("short mode page window not kept local");
   a_long_page_hold: assert property (byte_done && q.st == spi_port_pkg::ST_WDATA
                                      && offset_width_setting
                                      |=> q.push != in_window($past(q.offset), 1'b1))
      else $error("long mode page window not kept local");
   a_shift_on_launch: assert property (q.st == spi_port_pkg::ST_RDATA && !q.cs_n_s2
                                       && q.tx_cnt != 3'h0 && !load
                                       |=> (q.tx_cnt != $past(q.tx_cnt)) == $past(launch)
                                       && ($past(launch) -> q.sdio_out == $past(q.tx_sr[6])))
      else $error("read bit moved off its launch edge");

   c_write_word: cover property (q.push && buf_ready);
   c_read_load: cover property (load ##1 q.rd_req);
   c_page_short: cover property (byte_done && !offset_width_setting && in_window(q.offset, 1'b0));
   c_long_read: cover property (offset_width_setting && read_half_delay && q.sdio_oe);

endmodule

`default_nettype wire

/* verif/spi_host_model.sv */
// Purpose: behavioural spi host that drives the port's serial pins bit by bit
// Assumes: sclk period of 8 clk: 5 clk on the idle level, then 3 on the active level
// Notes: released data lines toggle each clk, so a stale bit never reads as good data
`default_nettype none

module spi_host_model (
   // bench clock
   input wire logic clk,
   // device side of the shared pad
   input wire logic sdio_out,
   input wire logic sdio_oe,
   // wiring and clock idle level
   input wire logic three_wire,
   input wire logic idle_high,
   // pins toward the device
   output logic sclk,
   output logic cs_n,
   output logic serial_data_input_pin,
   output logic sdio_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic ph = 1'b0; // active phase of sclk
   logic h_oe = 1'b0; // host drives a data line
   logic h_bit = 1'b0; // bit the host drives
   logic junk = 1'b0; // filler on released lines

   // idle level follows the edge choice, so the first edge is the sampling one
   assign sclk = ph ^ idle_high;
   // four-wire sends on its own pin, three-wire shares the pad with the device
   assign serial_data_input_pin = (h_oe && !three_wire) ? h_bit : junk;
   assign sdio_in = sdio_oe ? sdio_out : ((h_oe && three_wire) ? h_bit : junk);

   initial cs_n = 1'b1;

   // changing filler: the simulator must not settle a released line for us
   always @(posedge clk) begin
      junk <= ~junk;
   end

   // select the device and leave set-up time before the first edge
   task automatic start_burst();
      @(negedge clk);
      cs_n = 1'b0;
      repeat (4) @(negedge clk);
   endtask

   // a burst always ends here: host releases the data line, chip select goes high, then 8 clk idle
   task automatic stop_burst();
      repeat (2) @(negedge clk);
      h_oe = 1'b0;
      cs_n = 1'b1;
      repeat (8) @(negedge clk);
   endtask

   // one byte msb first; fewer than 8 bits leaves the byte broken
   task automatic xfer(input logic [7:0] tx, input int n, input logic drive,
         output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         h_oe = drive;
         h_bit = tx[i];
         repeat (5) @(negedge clk);
         rx[i] = sdio_in;
         ph = 1'b1;
         repeat (3) @(negedge clk);
         ph = 1'b0;
      end
   endtask
endmodule

`default_nettype wire

/* verif/spi_slave_paged_burst_port_tb.sv */
// Purpose: self-checking bench of the paged burst spi port
// Assumes: host model at 800 ns sclk; register side answers a fetch half a clk after rd_req
// Notes: fetched bytes follow a fixed function of the address, so reads are predictable
`default_nettype none

module spi_slave_paged_burst_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, sclk, cs_n, serial_data_input_pin, sdio_in, sdio_out, sdio_oe;
   logic offset_width_setting, spi_wire_mode_setting, clock_edge_select, read_half_delay;
   logic wr_valid, wr_ready, rd_req, overflow;
   logic rd_ack = 1'b0; // fetch answer strobe
   logic [7:0] rd_data = 8'h00; // fetch answer data
   logic [spi_port_pkg::ADDR_W-1:0] rd_addr;
   spi_port_pkg::wr_req_t wr_data;
   spi_port_pkg::wr_req_t wq[$]; // words taken by the consumer
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;

   spi_paged_port u_dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
      .serial_data_input_pin(serial_data_input_pin), .sdio_in(sdio_in),
      .sdio_out(sdio_out), .sdio_oe(sdio_oe), .offset_width_setting(offset_width_setting),
      .spi_wire_mode_setting(spi_wire_mode_setting), .clock_edge_select(clock_edge_select),
      .read_half_delay(read_half_delay), .wr_valid(wr_valid), .wr_data(wr_data),
      .wr_ready(wr_ready), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
      .rd_data(rd_data), .overflow(overflow));

   spi_host_model u_host (.clk(clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .three_wire(spi_wire_mode_setting), .idle_high(clock_edge_select), .sclk(sclk),
      .cs_n(cs_n), .serial_data_input_pin(serial_data_input_pin), .sdio_in(sdio_in));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // register content seen by reads; its own formula, unrelated to the design
   function automatic logic [7:0] rd_val(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction

   // register side drives its answer on the falling edge, well inside the 2 clk allowed
   always @(negedge clk) begin
      rd_ack <= (rd_req === 1'b1);
      if (rd_req === 1'b1) rd_data <= rd_val(rd_addr);
   end

   // words are taken at the rising edge on which the buffer pops them
   always @(posedge clk) begin
      if (wr_valid === 1'b1 && wr_ready === 1'b1) wq.push_back(wr_data);
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         $display("MISMATCH %0t run did not finish", $time);
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check_flag(input logic got, input logic exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // oldest collected word against the expected one; none at all is a mismatch
   task automatic check_word(input spi_port_pkg::wr_req_t exp);
      spi_port_pkg::wr_req_t got;
      got = 'x;
      if (wq.size() > 0) got = wq.pop_front();
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t write word got %h want %h", $time, got, exp);
      end
   endtask

   // one burst of host-driven bytes
   task automatic wburst(input logic [7:0] b [5], input int n);
      logic [7:0] r;
      u_host.start_burst();
      for (int i = 0; i < n; i++) u_host.xfer(b[i], 8, 1'b1, r);
      u_host.stop_burst();
   endtask

   // command bytes, then data bytes read with the host off the data line
   task automatic rburst(input logic [7:0] c [2], input int nc, input int nr,
         output logic [7:0] rx [2]);
      u_host.start_burst();
      for (int i = 0; i < nc; i++) u_host.xfer(c[i], 8, 1'b1, rx[0]);
      for (int i = 0; i < nr; i++) u_host.xfer(8'h00, 8, 1'b0, rx[i]);
      u_host.stop_burst();
   endtask

   // every edge, delay and wiring choice: page set, stalled write, two-byte read
   task automatic t_modes();
      logic [2:0] cfg [4] = '{3'b000, 3'b101, 3'b011, 3'b110};
      logic [7:0] rx [2];
      for (int k = 0; k < 4; k++) begin
         {clock_edge_select, read_half_delay, spi_wire_mode_setting} = cfg[k];
         repeat (4) @(negedge clk);
         wr_ready = 1'b0;
         wburst('{8'h7C, 8'h80, 8'hCB, 8'h10, 8'h20}, 5);
         wburst('{8'h64, 8'h50, 8'h51, 8'h00, 8'h00}, 3);
         check_flag(wq.size() == 0, 1'b1, "word passed a stalled consumer");
         wr_ready = 1'b1;
         repeat (4) @(negedge clk);
         check_word({16'hCBE4, 8'h50});
         check_word({16'hCBE5, 8'h51});
         rburst('{8'hA4, 8'h00}, 1, 2, rx);
         check_byte(rx[0], rd_val(16'hCBA4), "first read byte");
         check_byte(rx[1], rd_val(16'hCBA5), "second read byte");
         check_flag(sdio_oe, 1'b0, "pad driven after burst");
         check_flag(wq.size() == 0, 1'b1, "read made a write word");
      end
   endtask

   // reading the page window gives back the page bytes just written
   task automatic t_window();
      logic [7:0] rx [2];
      rburst('{8'hFC, 8'h00}, 1, 2, rx);
      check_byte(rx[0], 8'h80, "page byte 0");
      check_byte(rx[1], 8'hCB, "page byte 1");
   endtask

   // a half byte cut off by chip select must not shift the next command
   task automatic t_abort();
      logic [7:0] r;
      u_host.start_burst();
      u_host.xfer(8'h64, 4, 1'b1, r);
      u_host.stop_burst();
      wburst('{8'h64, 8'h77, 8'h00, 8'h00, 8'h00}, 2);
      check_word({16'hCBE4, 8'h77});
      check_flag(wq.size() == 0, 1'b1, "extra word after abort");
   endtask

   // two-byte offsets: page through 7FFD, then write and read 15-bit offsets
   task automatic t_two_byte();
      logic [7:0] rx [2];
      offset_width_setting = 1'b1;
      wburst('{8'h7F, 8'hFD, 8'h80, 8'h10, 8'h20}, 5);
      wburst('{8'h4B, 8'hE4, 8'h50, 8'h00, 8'h00}, 3);
      check_word({16'hCBE4, 8'h50});
      check_flag(wq.size() == 0, 1'b1, "page bytes forwarded");
      rburst('{8'hC0, 8'h24}, 2, 1, rx);
      check_byte(rx[0], rd_val(16'hC024), "long offset read");
      offset_width_setting = 1'b0;
   endtask

   // three words into a two-entry buffer with no drain: last one is lost
   task automatic t_overflow();
      wr_ready = 1'b0;
      wburst('{8'h64, 8'h01, 8'h02, 8'h03, 8'h00}, 4);
      check_flag(overflow, 1'b1, "no overflow on full buffer");
      wr_ready = 1'b1;
      repeat (4) @(negedge clk);
      check_word({16'h80E4, 8'h01});
      check_word({16'h80E5, 8'h02});
      check_flag(wq.size() == 0, 1'b1, "dropped word appeared");
   endtask

   // main sequence; inputs change on falling clk edges only
   initial begin
      rst = 1'b1;
      wr_ready = 1'b1;
      offset_width_setting = 1'b0;
      spi_wire_mode_setting = 1'b0;
      clock_edge_select = 1'b0;
      read_half_delay = 1'b0;
      repeat (12) @(negedge clk);
      check_flag(sdio_oe, 1'b0, "pad driven in reset");
      check_flag(wr_valid | rd_req | overflow, 1'b0, "outputs active in reset");
      rst = 1'b0;
      repeat (4) @(negedge clk);
      t_modes();
      t_window();
      t_abort();
      t_two_byte();
      t_overflow();
      tally_and_finish();
   end
endmodule

`default_nettype wire
